// file: rtl/tpsrb_top.sv
// What this block does
// - Test data sampled on rising test clock
// - Mode select advances selected port on rising
// - Test data output changes only on falling
// - Output driven only in Shift-IR or Shift-DR
// - Output comes from the selected port
// - Test reset clears every port asynchronously
// - Select high picks chip port, else core
// - Return synchronised test clock to the debugger
// - Latch one of four boot maps at reset
// - First fetch after reset at address zero
// - External reset valid after three low cycles
`timescale 1ns/1ps
`default_nettype none
`include "tpsrb_defs.svh"

module tpsrb_top #(
  parameter int RQ_CYCLES = `TPSRB_RST_QUAL_CYCLES,
  parameter int IR_W = `TPSRB_IR_W
) (
  // System clock domain
  input wire logic clk,
  input wire logic sys_rst,
  // Test clock domain, driven by the debugger
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tap_select_in,
  output logic tdo_out,
  output logic tdo_oe,
  output logic returned_test_clock,
  // Reset and boot straps
  input wire logic external_reset_n,
  input wire logic [`TPSRB_BOOT_W-1:0] boot_mode_in,
  output logic internal_reset,
  output logic [`TPSRB_BOOT_W-1:0] boot_map_sel,
  output logic [`TPSRB_BOOT_MAPS-1:0] boot_map_onehot,
  output logic fetch_start,
  output logic [31:0] fetch_addr
);

  // Counter width covers the full qualification count
  localparam int RQ_W = $clog2(RQ_CYCLES + 1);

  // The qualifier needs at least one sample, and the straps must span the maps
  if (RQ_CYCLES < 1) begin : g_bad_rq
    $error("tpsrb_top: RQ_CYCLES must be at least 1");
  end
  if ((1 << `TPSRB_BOOT_W) != `TPSRB_BOOT_MAPS) begin : g_bad_boot
    $error("tpsrb_top: boot strap width does not match map count");
  end

  // Test clock domain
  // All flops below this point run on the debugger's test clock
  // and are cleared by the test reset pin

  logic trst_s1_ff; // Reset release stage one
  logic trst_s2_ff; // Reset release stage two, used as port reset
  logic sel_s1_ff; // Port select synchroniser stage one
  logic sel_s2_ff; // Port select synchroniser stage two
  logic tdo_ff; // Test data output flop
  logic tdo_oe_ff; // Test data output enable flop
  wire logic tap_rst_n; // Reset seen by the ports
  wire logic sel_idx; // Index of the active port
  wire logic [`TPSRB_TAP_COUNT-1:0] tap_tdo; // Serial out of each port
  wire logic [`TPSRB_TAP_COUNT-1:0] tap_shift; // Shift state of each port
  wire logic sel_tdo; // Serial out of the active port
  wire logic sel_shift; // Active port is shifting

  // Test reset asserts at once and releases on a rising test clock,
  // so a port never sees a release too close to a clock edge
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      trst_s1_ff <= 1'b0;
      trst_s2_ff <= 1'b0;
    end else begin
      trst_s1_ff <= 1'b1;
      trst_s2_ff <= trst_s1_ff;
    end
  end

  assign tap_rst_n = trst_s2_ff;

  // The select pin is a free level; two stages keep the mux clean.
  // Trade-off: a change takes effect two test clocks later.
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      sel_s1_ff <= 1'b0;
      sel_s2_ff <= 1'b0;
    end else begin
      sel_s1_ff <= tap_select_in;
      sel_s2_ff <= sel_s1_ff;
    end
  end

  // Index 1 is the chip-level port, so the select level is the index
  assign sel_idx = sel_s2_ff;

  // One lane per port; core port sits at index 0
  tpsrb_tap_if tap_if[`TPSRB_TAP_COUNT] ();

  // Both ports share the data input; only the selected one sees mode select
  for (genvar i = 0; i < `TPSRB_TAP_COUNT; i++) begin : g_tap
    localparam logic [31:0] ID = (i == `TPSRB_TAP_CHIP) ? `TPSRB_CHIP_IDCODE :
                                                          `TPSRB_CORE_IDCODE;
    // Deselected port is parked by holding mode select high
    assign tap_if[i].tms = (sel_idx == 1'(i)) ? tms : 1'b1;
    // Data input reaches every port; the selected one shifts it
    assign tap_if[i].tdi = tdi;
    // Gather the lane outputs into plain vectors for the mux
    assign tap_tdo[i] = tap_if[i].tdo;
    assign tap_shift[i] = tap_if[i].shifting;
    tpsrb_tap #(
      .IR_W(IR_W),
      .IDCODE(ID)
    ) u_tap (
      .tck(tck),
      .tap_rst_n(tap_rst_n),
      .port_if(tap_if[i])
    );
  end

  // Output source follows the select
  assign sel_tdo = tap_tdo[sel_idx];
  assign sel_shift = tap_shift[sel_idx];

  // Output moves half a cycle after the state so the debugger samples it
  // on the next rising edge with a full half period of setup
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= sel_tdo;
      tdo_oe_ff <= sel_shift;
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // System clock domain
  // Flops below run on the system clock; test clock signals enter
  // only through the two-stage synchroniser

  logic tck_s1_ff; // Test clock synchroniser stage one
  logic tck_s2_ff; // Test clock synchroniser stage two
  logic returned_test_clock_ff; // Returned test clock flop
  logic rst_s1_ff; // External reset synchroniser stage one
  logic rst_s2_ff; // External reset synchroniser stage two
  tpsrb_pkg::tpsrb_boot_mode_t bm_s1_ff; // Boot strap stage one
  tpsrb_pkg::tpsrb_boot_mode_t bm_s2_ff; // Boot strap stage two
  tpsrb_pkg::tpsrb_rq_state_t rq_state_ff; // Qualifier state
  tpsrb_pkg::tpsrb_rq_state_t nxt_rq_state; // Next qualifier state
  logic [RQ_W-1:0] rq_cnt_ff; // Consecutive low samples
  logic [RQ_W-1:0] nxt_rq_cnt; // Next low sample count
  logic int_rst_ff; // Internal reset flop
  tpsrb_pkg::tpsrb_boot_mode_t boot_map_ff; // Latched boot map
  logic fetch_start_ff; // First fetch request pulse
  logic [31:0] fetch_addr_ff; // First fetch address
  wire logic ext_low; // Synchronised external reset is asserted
  wire logic rq_reached; // Low long enough to count as a reset
  wire logic rq_release; // Held reset ends this cycle
  wire logic [RQ_W-1:0] rq_cnt_inc; // Low sample count plus one

  // Test clock brought into the system domain and sent back out.
  // Limitation: the debugger must keep its test clock well below half
  // the system clock, or returned edges are lost.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      returned_test_clock_ff <= 1'b0;
    end else begin
      tck_s1_ff <= tck;
      tck_s2_ff <= tck_s1_ff;
      returned_test_clock_ff <= tck_s2_ff;
    end
  end

  assign returned_test_clock = returned_test_clock_ff;

  // Pin synchronisers for the reset input and the boot straps.
  // The straps are static while reset is held, so per-bit stages suffice.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_s1_ff <= 1'b0; // Start asserted so straps settle before release
      rst_s2_ff <= 1'b0;
      bm_s1_ff <= '0;
      bm_s2_ff <= '0;
    end else begin
      rst_s1_ff <= external_reset_n;
      rst_s2_ff <= rst_s1_ff;
      bm_s1_ff <= boot_mode_in;
      bm_s2_ff <= bm_s1_ff;
    end
  end

  // Qualifier decode
  assign ext_low = ~rst_s2_ff;
  assign rq_cnt_inc = rq_cnt_ff + RQ_W'(1);
  assign rq_reached = ext_low && (rq_cnt_inc >= RQ_W'(RQ_CYCLES));
  assign rq_release = (rq_state_ff == tpsrb_pkg::TPSRB_RQ_HELD) && !ext_low;

  // Short low pulses are rejected: the count restarts on any high sample
  always_comb begin
    nxt_rq_state = rq_state_ff;
    nxt_rq_cnt = rq_cnt_ff;
    case (rq_state_ff)
      tpsrb_pkg::TPSRB_RQ_RUN: begin
        if (rq_reached) begin
          nxt_rq_state = tpsrb_pkg::TPSRB_RQ_HELD;
        end else if (ext_low) begin
          nxt_rq_state = tpsrb_pkg::TPSRB_RQ_ARMING;
          nxt_rq_cnt = RQ_W'(1);
        end
      end
      tpsrb_pkg::TPSRB_RQ_ARMING: begin
        if (!ext_low) begin // Glitch, back to normal running
          nxt_rq_state = tpsrb_pkg::TPSRB_RQ_RUN;
          nxt_rq_cnt = '0;
        end else if (rq_reached) begin
          nxt_rq_state = tpsrb_pkg::TPSRB_RQ_HELD;
        end else begin
          nxt_rq_cnt = rq_cnt_inc;
        end
      end
      tpsrb_pkg::TPSRB_RQ_HELD: begin
        if (!ext_low) begin // Reset released
          nxt_rq_state = tpsrb_pkg::TPSRB_RQ_RUN;
          nxt_rq_cnt = '0;
        end
      end
      default: begin
        nxt_rq_state = tpsrb_pkg::TPSRB_RQ_HELD;
        nxt_rq_cnt = '0;
      end
    endcase
  end

  // System reset counts as power-up: start held so the straps are latched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rq_state_ff <= tpsrb_pkg::TPSRB_RQ_HELD;
      rq_cnt_ff <= '0;
    end else begin
      rq_state_ff <= nxt_rq_state;
      rq_cnt_ff <= nxt_rq_cnt;
    end
  end

  // Internal reset follows the qualified state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_rst_ff <= 1'b1;
    end else begin
      int_rst_ff <= (nxt_rq_state == tpsrb_pkg::TPSRB_RQ_HELD);
    end
  end

  // Boot map is caught at the release edge and then stays fixed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_map_ff <= '0;
    end else if (rq_release) begin
      boot_map_ff <= bm_s2_ff;
    end
  end

  // First fetch request goes out as reset ends, always at the vector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_start_ff <= 1'b0;
      fetch_addr_ff <= `TPSRB_RESET_VECTOR;
    end else begin
      fetch_start_ff <= rq_release;
      fetch_addr_ff <= `TPSRB_RESET_VECTOR;
    end
  end

  // Map decode; one-hot copy is registered so it leaves from a flop
  logic [`TPSRB_BOOT_MAPS-1:0] onehot_ff; // Decoded boot map
  wire logic [`TPSRB_BOOT_MAPS-1:0] nxt_onehot; // Decode of the caught map

  for (genvar m = 0; m < `TPSRB_BOOT_MAPS; m++) begin : g_map
    assign nxt_onehot[m] = (boot_map_ff == `TPSRB_BOOT_W'(m));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      onehot_ff <= '0;
    end else begin
      onehot_ff <= nxt_onehot;
    end
  end

  assign internal_reset = int_rst_ff;
  assign boot_map_sel = boot_map_ff;
  assign boot_map_onehot = onehot_ff;
  assign fetch_start = fetch_start_ff;
  assign fetch_addr = fetch_addr_ff;

endmodule

`default_nettype wire

// file: rtl/tpsrb_defs.svh
`ifndef TPSRB_DEFS_SVH
`define TPSRB_DEFS_SVH

// Consecutive system clock cycles that the external reset must stay low
`define TPSRB_RST_QUAL_CYCLES 3

// Address of the first instruction fetch after any reset
`define TPSRB_RESET_VECTOR 32'h0000_0000

// Width of the boot memory-map select straps
`define TPSRB_BOOT_W 2

// Number of boot memory maps reachable through the straps
`define TPSRB_BOOT_MAPS 4

// Instruction register width of each test access port
`define TPSRB_IR_W 4

// Instruction codes; any code not listed behaves as bypass
`define TPSRB_IR_BYPASS 4'hF
`define TPSRB_IR_IDCODE 4'h1

// Pattern loaded into the instruction shifter on Capture-IR
`define TPSRB_IR_CAPTURE 4'h1

// Identification words; both values are arbitrary
`define TPSRB_CHIP_IDCODE 32'h1A5A_0001
`define TPSRB_CORE_IDCODE 32'h2B6B_0001

// Mux index of the chip-level port; the processor core port is the other one
`define TPSRB_TAP_CHIP 1
`define TPSRB_TAP_COUNT 2

`endif

// file: rtl/tpsrb_pkg.sv
package tpsrb_pkg;

  // Sixteen controller states of the test access port
  typedef enum logic [3:0] {
    TPSRB_TLR, TPSRB_RTI,
    TPSRB_SEL_DR, TPSRB_CAP_DR, TPSRB_SHIFT_DR, TPSRB_EXIT1_DR,
    TPSRB_PAUSE_DR, TPSRB_EXIT2_DR, TPSRB_UPD_DR,
    TPSRB_SEL_IR, TPSRB_CAP_IR, TPSRB_SHIFT_IR, TPSRB_EXIT1_IR,
    TPSRB_PAUSE_IR, TPSRB_EXIT2_IR, TPSRB_UPD_IR
  } tpsrb_tap_state_t;

  // External reset qualifier states
  typedef enum logic [1:0] {
    TPSRB_RQ_RUN, TPSRB_RQ_ARMING, TPSRB_RQ_HELD
  } tpsrb_rq_state_t;

  // Boot memory-map selection
  typedef logic [1:0] tpsrb_boot_mode_t;

endpackage

// file: rtl/tpsrb_tap_if.sv
`timescale 1ns/1ps
`default_nettype none

// Serial lane between the port multiplexer and one test access port
interface tpsrb_tap_if;
  logic tms; // Mode select, forced high while the port is deselected
  logic tdi; // Serial data in
  logic tdo; // Serial data out, bit now at the head of the active shifter
  logic shifting; // High in Shift-IR or Shift-DR
  modport tap (input tms, input tdi, output tdo, output shifting);
  modport ctl (output tms, output tdi, input tdo, input shifting);
endinterface

`default_nettype wire

// file: rtl/tpsrb_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpsrb_defs.svh"

module tpsrb_tap #(
  parameter int IR_W = `TPSRB_IR_W,
  parameter logic [31:0] IDCODE = `TPSRB_CHIP_IDCODE
) (
  input wire logic tck,
  input wire logic tap_rst_n,
  tpsrb_tap_if.tap port_if
);

  // The capture pattern needs at least two instruction bits
  if (IR_W < 2) begin : g_bad_ir_w
    $error("tpsrb_tap: IR_W must be at least 2");
  end

  tpsrb_pkg::tpsrb_tap_state_t state_ff; // Controller state
  tpsrb_pkg::tpsrb_tap_state_t nxt_state; // Next controller state
  logic [IR_W-1:0] ir_shift_ff; // Instruction shifter
  logic [IR_W-1:0] ir_ff; // Active instruction
  logic [31:0] dr_ff; // Shared data shifter
  wire logic sel_idcode; // Identification register selected
  wire logic in_shift_ir; // Shifting instruction bits
  wire logic in_shift_dr; // Shifting data bits

  assign sel_idcode = (ir_ff == IR_W'(`TPSRB_IR_IDCODE));
  assign in_shift_ir = (state_ff == tpsrb_pkg::TPSRB_SHIFT_IR);
  assign in_shift_dr = (state_ff == tpsrb_pkg::TPSRB_SHIFT_DR);
  assign port_if.shifting = in_shift_ir | in_shift_dr;
  assign port_if.tdo = in_shift_ir ? ir_shift_ff[0] : dr_ff[0];

  // State walk on the sampled mode select; Exit2 with mode select high goes to Exit1, not Update
  always_comb begin
    case (state_ff)
      tpsrb_pkg::TPSRB_TLR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_TLR : tpsrb_pkg::TPSRB_RTI;
      tpsrb_pkg::TPSRB_RTI: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_SEL_DR : tpsrb_pkg::TPSRB_RTI;
      tpsrb_pkg::TPSRB_SEL_DR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_SEL_IR : tpsrb_pkg::TPSRB_CAP_DR;
      tpsrb_pkg::TPSRB_CAP_DR, tpsrb_pkg::TPSRB_SHIFT_DR, tpsrb_pkg::TPSRB_EXIT2_DR:
        nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_EXIT1_DR : tpsrb_pkg::TPSRB_SHIFT_DR;
      tpsrb_pkg::TPSRB_EXIT1_DR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_UPD_DR : tpsrb_pkg::TPSRB_PAUSE_DR;
      tpsrb_pkg::TPSRB_PAUSE_DR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_EXIT2_DR : tpsrb_pkg::TPSRB_PAUSE_DR;
      tpsrb_pkg::TPSRB_SEL_IR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_TLR : tpsrb_pkg::TPSRB_CAP_IR;
      tpsrb_pkg::TPSRB_CAP_IR, tpsrb_pkg::TPSRB_SHIFT_IR, tpsrb_pkg::TPSRB_EXIT2_IR:
        nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_EXIT1_IR : tpsrb_pkg::TPSRB_SHIFT_IR;
      tpsrb_pkg::TPSRB_EXIT1_IR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_UPD_IR : tpsrb_pkg::TPSRB_PAUSE_IR;
      tpsrb_pkg::TPSRB_PAUSE_IR: nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_EXIT2_IR : tpsrb_pkg::TPSRB_PAUSE_IR;
      tpsrb_pkg::TPSRB_UPD_DR, tpsrb_pkg::TPSRB_UPD_IR:
        nxt_state = port_if.tms ? tpsrb_pkg::TPSRB_SEL_DR : tpsrb_pkg::TPSRB_RTI;
      default: nxt_state = tpsrb_pkg::TPSRB_TLR;
    endcase
  end

  // State advances on rising test clock; test reset wins at once
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_ff <= tpsrb_pkg::TPSRB_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Instruction path: capture, shift in serial data, update
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift_ff <= IR_W'(`TPSRB_IR_CAPTURE);
      ir_ff <= IR_W'(`TPSRB_IR_IDCODE);
    end else begin
      case (state_ff)
        tpsrb_pkg::TPSRB_TLR: ir_ff <= IR_W'(`TPSRB_IR_IDCODE);
        tpsrb_pkg::TPSRB_CAP_IR: ir_shift_ff <= IR_W'(`TPSRB_IR_CAPTURE);
        tpsrb_pkg::TPSRB_SHIFT_IR: ir_shift_ff <= {port_if.tdi, ir_shift_ff[IR_W-1:1]};
        tpsrb_pkg::TPSRB_UPD_IR: ir_ff <= ir_shift_ff;
        default: ir_ff <= ir_ff;
      endcase
    end
  end

  // Data path: identification word or one-bit bypass
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      dr_ff <= 32'h0000_0000;
    end else if (state_ff == tpsrb_pkg::TPSRB_CAP_DR) begin
      dr_ff <= sel_idcode ? IDCODE : 32'h0000_0000;
    end else if (in_shift_dr) begin
      // Bypass keeps only bit 0 so the chain stays one stage long
      dr_ff <= sel_idcode ? {port_if.tdi, dr_ff[31:1]} : {31'h0000_0000, port_if.tdi};
    end
  end

endmodule

`default_nettype wire

// file: verif/tpsrb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpsrb_defs.svh"

// Pin-level checks for both clock domains
module tpsrb_asserts #(
  parameter int RQ_CYCLES = 3,
  parameter int IR_W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tap_select_in,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic returned_test_clock,
  input wire logic external_reset_n,
  input wire logic [`TPSRB_BOOT_W-1:0] boot_mode_in,
  input wire logic internal_reset,
  input wire logic [`TPSRB_BOOT_W-1:0] boot_map_sel,
  input wire logic [`TPSRB_BOOT_MAPS-1:0] boot_map_onehot,
  input wire logic fetch_start,
  input wire logic [31:0] fetch_addr
);
  logic tdo_at_rise; // Data bit seen at the last rising test clock
  logic oe_at_rise; // Enable seen at the last rising test clock

  // Snapshot at rising edge; the next falling edge must still see it
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_at_rise <= 1'b0;
      oe_at_rise <= 1'b0;
    end else begin
      tdo_at_rise <= tdo_out;
      oe_at_rise <= tdo_oe;
    end
  end

  a_tdo_hold: assert property (@(negedge tck) disable iff (!trst_n)
    tdo_out == tdo_at_rise && tdo_oe == oe_at_rise)
    else $error("tdo moved between falling edges");
  a_oe_enter: assert property (@(negedge tck) disable iff (!trst_n)
    $rose(tdo_oe) |-> !$past(tms))
    else $error("tdo enabled without a shift entry");
  a_oe_stay: assert property (@(negedge tck) disable iff (!trst_n)
    tdo_oe && !tms |=> tdo_oe)
    else $error("tdo released while shifting");
  a_oe_exit: assert property (@(negedge tck) disable iff (!trst_n)
    tdo_oe && tms |=> !tdo_oe)
    else $error("tdo still driven after shift exit");
  a_trst_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !trst_n |-> !tdo_oe && !tdo_out)
    else $error("tdo active under test reset");
  a_rtc_delay: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
    returned_test_clock == $past(tck, 3))
    else $error("returned clock not three cycles behind");
  a_rst_qualify: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(internal_reset) |->
    !$past(external_reset_n, 3) && !$past(external_reset_n, 4) && !$past(external_reset_n, 5))
    else $error("reset taken from a short low pulse");
  a_rst_accept: assert property (@(posedge clk) disable iff (sys_rst)
    (!external_reset_n) [*3] |-> ##[1:3] internal_reset)
    else $error("qualified reset not taken");
  a_boot_latch: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(internal_reset) |->
    ##[0:1] (fetch_start && fetch_addr == 32'h0 && boot_map_sel == boot_mode_in))
    else $error("boot map or first fetch wrong at release");
  a_onehot: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_start |-> ##1 (!fetch_start && boot_map_onehot == (4'h1 << boot_map_sel)))
    else $error("boot map decode wrong or fetch strobe too long");
endmodule

bind tpsrb_top tpsrb_asserts #(.RQ_CYCLES(RQ_CYCLES), .IR_W(IR_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
  .tap_select_in(tap_select_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
  .returned_test_clock(returned_test_clock), .external_reset_n(external_reset_n),
  .boot_mode_in(boot_mode_in), .internal_reset(internal_reset),
  .boot_map_sel(boot_map_sel), .boot_map_onehot(boot_map_onehot),
  .fetch_start(fetch_start), .fetch_addr(fetch_addr)
);

`default_nettype wire

// file: verif/tpsrb_dbg.sv
`timescale 1ns/1ps
`default_nettype none

// Debug pod model; it owns the test clock and parks it low between frames
module tpsrb_dbg (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  logic last_bit = 1'b0; // Line level seen at the previous rising edge
  logic tdo_line; // Level the pod reads on the data output wire

  // No pull on the wire, so a released line keeps flipping
  assign tdo_line = (tdo_oe === 1'b1) ? tdo_out : ~last_bit;

  // Power-up levels; test logic held in reset until a frame starts
  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    #1;
    trst_n = 1'b0; // A real falling edge, so every test flop clears
  end

  // Track the wire so a floating line never repeats a value
  always @(posedge tck) begin
    last_bit <= tdo_line;
  end

  // One test clock period; inputs move only while the clock is low
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16;
    tck = 1'b1;
    q = tdo_line; // Taken at the rising edge, as a real pod does
    #16;
    tck = 1'b0;
  endtask

  // Drive the test reset pin; the clock stays still meanwhile
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpsrb_defs.svh"

// Self-checking bench for test port, reset qualifier and boot straps
module tb_top;
  logic clk = 1'b0; // System clock, 100 MHz
  logic sys_rst = 1'b1; // Held from time zero
  logic tap_select_in; // Port select pin
  logic external_reset_n; // External reset pin
  logic [1:0] boot_mode_in; // Boot strap pins
  wire tck, trst_n, tms, tdi; // Driven by the pod model
  logic tdo_out, tdo_oe, returned_test_clock, internal_reset, fetch_start;
  logic [1:0] boot_map_sel;
  logic [3:0] boot_map_onehot;
  logic [31:0] fetch_addr;
  int failures = 0;
  int checks = 0;
  int returned_test_clock_n = 0; // Rising edges seen on the returned test clock

  // Free-running system clock
  initial begin
    forever #5 clk = ~clk;
  end

  tpsrb_top DUT (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tap_select_in(tap_select_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .returned_test_clock(returned_test_clock), .external_reset_n(external_reset_n),
    .boot_mode_in(boot_mode_in), .internal_reset(internal_reset),
    .boot_map_sel(boot_map_sel), .boot_map_onehot(boot_map_onehot),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr)
  );

  tpsrb_dbg DBG (
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe)
  );

  // Count returned clock pulses to compare with test clock pulses
  always @(posedge returned_test_clock) begin
    returned_test_clock_n++;
  end

  // Compare one observed value with its expectation
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One test clock with a mode bit and no data of interest
  task automatic tk(input logic m);
    logic q;
    DBG.step(m, 1'b0, q);
  endtask

  // Bounded wait for the first fetch strobe after a reset release
  task automatic wait_fetch();
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("fetch_start", fetch_start, 1);
  endtask

  // Read the identification word of one port right after test reset
  task automatic t_idcode(input logic sel, input logic [31:0] exp);
    logic [31:0] w;
    logic b;
    @(negedge clk);
    tap_select_in = sel;
    DBG.set_trst(1'b0);
    #20;
    DBG.set_trst(1'b1);
    repeat (3) tk(1'b1); // Release and select both need rising edges
    // Even offset keeps test clock edges off rising system clock edges
    #2;
    check("oe_idle", tdo_oe, 0);
    tk(1'b0);
    tk(1'b1);
    tk(1'b0);
    tk(1'b0); // Now in Shift-DR
    for (int i = 0; i < 32; i++) begin
      DBG.step(i == 31, 1'b0, b);
      w[i] = b;
    end
    #2;
    check("idcode", w, exp);
    check("oe_exit", tdo_oe, 0);
    tk(1'b1);
    tk(1'b0);
  endtask

  // Load bypass, read the capture pattern, then stream a byte through
  task automatic t_bypass();
    logic [3:0] ir;
    logic [7:0] dr;
    logic b;
    logic [3:0] op;
    logic [7:0] pat;
    int n0;
    #40; // Let the last returned pulse of the previous test pass
    n0 = returned_test_clock_n;
    op = `TPSRB_IR_BYPASS;
    pat = 8'hA5;
    tk(1'b1);
    tk(1'b1);
    tk(1'b0);
    tk(1'b0); // Now in Shift-IR
    for (int i = 0; i < 4; i++) begin
      DBG.step(i == 3, op[i], b);
      ir[i] = b;
    end
    check("ir_capture", ir, `TPSRB_IR_CAPTURE);
    tk(1'b1);
    tk(1'b1);
    tk(1'b0);
    tk(1'b0); // Now in Shift-DR through the one-bit path
    for (int i = 0; i < 8; i++) begin
      DBG.step(i == 7, pat[i], b);
      dr[i] = b;
    end
    check("bypass", dr, 8'h4A);
    tk(1'b1);
    tk(1'b0);
    #40;
    check("returned_test_clock_edges", returned_test_clock_n - n0, 22);
  endtask

  // Pull test reset in mid-shift with the test clock stopped
  task automatic t_trst();
    tk(1'b1);
    tk(1'b0);
    tk(1'b0); // Now in Shift-DR
    #2;
    check("oe_shift", tdo_oe, 1);
    DBG.set_trst(1'b0);
    #20;
    check("oe_trst", tdo_oe, 0);
    check("tdo_trst", tdo_out, 0);
    DBG.set_trst(1'b1);
    repeat (3) tk(1'b1);
  endtask

  // Refuse a short low pulse, then latch every boot strap value
  task automatic t_boot();
    @(negedge clk);
    external_reset_n = 1'b0;
    repeat (2) @(negedge clk);
    external_reset_n = 1'b1; // Two cycles low is too short
    repeat (8) @(negedge clk);
    check("short_low", internal_reset, 0);
    for (int m = 0; m < 4; m++) begin
      boot_mode_in = 2'(m);
      external_reset_n = 1'b0;
      repeat (8) @(negedge clk);
      check("rst_held", internal_reset, 1);
      external_reset_n = 1'b1;
      wait_fetch();
      check("boot_sel", boot_map_sel, m);
      check("fetch_addr", fetch_addr, `TPSRB_RESET_VECTOR);
      @(negedge clk);
      check("onehot", boot_map_onehot, 32'h1 << m);
    end
  endtask

  // Main sequence
  initial begin
    tap_select_in = 1'b0;
    external_reset_n = 1'b1;
    boot_mode_in = 2'h0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    wait_fetch();
    check("boot_pwrup", boot_map_sel, 0);
    t_idcode(1'b1, `TPSRB_CHIP_IDCODE);
    t_bypass();
    t_idcode(1'b0, `TPSRB_CORE_IDCODE);
    t_bypass();
    t_trst();
    t_boot();
    end_sim();
  end

  // Cut a hang short; the full run needs well under 20 us
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule

`default_nettype wire
